//--- dv/bcc_core_model.sv
`timescale 1ns/10ps
module bcc_core_model (
	input wire logic clk_in, // bus clock
	input wire logic nrst_in, // sync reset, active low
	input wire logic go_in, // start one bus cycle
	input wire logic [15:0] addr_in, // cpu address to drive
	input wire logic [21:0] xaddr_in, // paged address to drive
	input wire logic rd_in, // 1 read, 0 write
	input wire logic exec_in, // the opcode will really execute
	input wire logic slow_in, // late instruction boundary
	output logic [15:0] cab_out, // cpu address bus
	output logic [21:0] xab_out, // expanded address bus
	output logic rd_out, // bus direction
	output logic valid_out, // bus cycle valid
	output logic exec_out, // opcode about to execute
	output logic bnd_out // instruction boundary
);
	logic [2:0] wait_cnt;
	logic pend_exec;

	// ----------------------------------------
	// bus cycle: one valid cycle, then the bus shows inverted junk
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			valid_out <= 1'b0;
			cab_out <= 16'hffff;
			xab_out <= 22'h3fffff;
			rd_out <= 1'b0;
		end else if (go_in) begin
			valid_out <= 1'b1;
			cab_out <= addr_in;
			xab_out <= xaddr_in;
			rd_out <= rd_in;
		end else if (valid_out) begin
			// released bus must not keep a value that could still match
			valid_out <= 1'b0;
			cab_out <= ~cab_out;
			xab_out <= ~xab_out;
			rd_out <= ~rd_out;
		end
	end

	// boundary, fast or slow; execute pulse only when asked
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			wait_cnt <= 3'h0;
			pend_exec <= 1'b0;
			bnd_out <= 1'b0;
			exec_out <= 1'b0;
		end else if (go_in) begin
			wait_cnt <= slow_in ? 3'h4 : 3'h1;
			pend_exec <= exec_in;
			bnd_out <= 1'b0;
			exec_out <= 1'b0;
		end else begin
			bnd_out <= (wait_cnt == 3'h1);
			exec_out <= (wait_cnt == 3'h1) & pend_exec;
			wait_cnt <= (wait_cnt != 3'h0) ? wait_cnt - 3'h1 : 3'h0;
		end
	end
endmodule

//--- dv/tb_breakpoint_comparator_c.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_breakpoint_comparator_c;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic wr = 1'b0, rd = 1'b0, go = 1'b0, m_rd = 1'b0, m_exec = 1'b0, slow = 1'b0;
	logic [15:0] m_addr = 16'h0000, cab;
	logic [21:0] m_xaddr = 22'h000000, expanded_address_bus;
	logic brd, bval, bexec, bbnd, brk, bgnd, btag, bko, fm, abt, last_tag, cmo;
	int err_count = 0, n_tests = 0, brk_cnt = 0, mat_cnt = 0;

	always #4 clk_in = ~clk_in;

	bcc_core_model core (.clk_in(clk_in), .nrst_in(nrst_in), .go_in(go), .addr_in(m_addr),
		.xaddr_in(m_xaddr), .rd_in(m_rd), .exec_in(m_exec), .slow_in(slow), .cab_out(cab),
		.xab_out(expanded_address_bus), .rd_out(brd), .valid_out(bval), .exec_out(bexec), .bnd_out(bbnd));
	bcc_comparator_c DUT (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.cpu_address_bus_in(cab), .expanded_address_bus_in(expanded_address_bus), .bus_read_in(brd),
		.bus_valid_in(bval), .opcode_exec_in(bexec), .instr_boundary_in(bbnd),
		.break_req_out(brk), .break_to_background_out(bgnd), .break_tagged_out(btag),
		.breakpoint_only_mode_out(bko), .full_mode_out(fm), .ab_tagged_out(abt),
		.c_match_out(cmo));

	// count one-cycle break pulses and keep the tag seen with the last one
	always @(posedge clk_in) begin
		if (brk === 1'b1) begin
			brk_cnt <= brk_cnt + 1;
			last_tag <= btag;
		end
		if (cmo === 1'b1) begin
			mat_cnt <= mat_cnt + 1;
		end
	end

	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		#1;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		`CHK(rdata, exp)
	endtask

	// one core bus cycle, then count the breaks it caused
	task automatic bus_chk(input logic [15:0] a, input logic [21:0] x, input logic r,
		input logic e, input int n);
		brk_cnt = 0;
		mat_cnt = 0;
		@(posedge clk_in);
		m_addr <= a;
		m_xaddr <= x;
		m_rd <= r;
		m_exec <= e;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (9) @(posedge clk_in);
		#1;
		`CHK(brk_cnt, n)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			rd_chk(8'h25 + 8'(i), 8'h00);
		end
		wr_reg(8'h30, 8'h5a);
		rd_chk(8'h30, 8'h00);
	endtask

	task automatic t_modes();
		wr_reg(8'h28, 8'hd0);
		`CHK({bko, fm, abt, bgnd}, 4'b1110)
		wr_reg(8'h20, 8'h80);
		rd_chk(8'h20, 8'h00);
		wr_reg(8'h28, 8'h70);
		`CHK({bko, fm, abt, bgnd}, 4'b0001)
	endtask

	task automatic t_plain();
		wr_reg(8'h25, 8'h00);
		wr_reg(8'h26, 8'h12);
		wr_reg(8'h27, 8'h34);
		wr_reg(8'h28, 8'h88);
		bus_chk(16'h1234, 22'h3fffff, 1'b0, 1'b0, 1);
		`CHK(last_tag, 1'b0)
		rd_chk(8'h21, 8'h01);
		wr_reg(8'h21, 8'h00);
		rd_chk(8'h21, 8'h00);
		bus_chk(16'h1235, 22'h3fffff, 1'b0, 1'b0, 0);
		`CHK(mat_cnt, 0)
		bus_chk(16'h9234, 22'h3fffff, 1'b0, 1'b0, 0);
	endtask

	// page kind 01: page bits and xab 15..14 join the compare
	task automatic t_paged();
		wr_reg(8'h25, 8'h45);
		wr_reg(8'h26, 8'hd2);
		bus_chk(16'h1234, 22'h05c000, 1'b0, 1'b0, 1);
		bus_chk(16'h1234, 22'h06c000, 1'b0, 1'b0, 0);
		bus_chk(16'h1234, 22'h058000, 1'b0, 1'b0, 0);
		wr_reg(8'h25, 8'hc5);
		bus_chk(16'h1234, 22'h05c000, 1'b0, 1'b0, 1);
		wr_reg(8'h25, 8'h85);
		bus_chk(16'h1234, 22'h05c000, 1'b0, 1'b0, 0);
		bus_chk(16'hd234, 22'h3fc000, 1'b0, 1'b0, 1);
	endtask

	task automatic t_dir();
		wr_reg(8'h25, 8'h00);
		wr_reg(8'h26, 8'h12);
		wr_reg(8'h28, 8'h8b);
		bus_chk(16'h1234, 22'h000000, 1'b1, 1'b0, 1);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 0);
		wr_reg(8'h28, 8'h8a);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 1);
		bus_chk(16'h1234, 22'h000000, 1'b1, 1'b0, 0);
		wr_reg(8'h28, 8'h89);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 1);
	endtask

	// tagged: a fetched opcode that never executes must not break
	task automatic t_tag();
		wr_reg(8'h28, 8'h8c);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 0);
		slow = 1'b1;
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b1, 1);
		slow = 1'b0;
		`CHK(last_tag, 1'b1)
	endtask

	task automatic t_capture();
		wr_reg(8'h28, 8'h08);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 0);
		`CHK(mat_cnt, 1)
		wr_reg(8'h20, 8'h80);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 1);
		wr_reg(8'h20, 8'h81);
		bus_chk(16'h1234, 22'h000000, 1'b0, 1'b0, 0);
	endtask

	task automatic t_loop_arm();
		wr_reg(8'h26, 8'h77);
		wr_reg(8'h28, 8'h0c);
		wr_reg(8'h20, 8'hc1);
		rd_chk(8'h26, 8'h00);
		rd_chk(8'h27, 8'h00);
		rd_chk(8'h28, 8'h04);
	endtask

	task automatic final_report();
		$display("mismatches %0d of %0d checks", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk_in);
		nrst_in <= 1'b1;
		t_regs();
		t_modes();
		t_plain();
		t_paged();
		t_dir();
		t_tag();
		t_capture();
		t_loop_arm();
		final_report();
	end

	// the whole run needs well under 1500 cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		err_count++;
		final_report();
	end
endmodule

//--- hw/bcc_comparator_c.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
module bcc_comparator_c #(
	parameter int ADDR_W = bcc_pkg::ADDR_W, // cpu address width
	parameter int XADDR_W = bcc_pkg::XADDR_W // expanded address width
) (
	input wire logic clk_in, // bus clock
	input wire logic nrst_in, // sync reset, active low
	input wire logic [7:0] reg_addr_in, // register offset
	input wire logic [7:0] reg_wdata_in, // write data
	input wire logic reg_wr_in, // write strobe
	input wire logic reg_rd_in, // read strobe
	output logic [7:0] reg_rdata_out, // read data, cycle after strobe
	input wire logic [ADDR_W-1:0] cpu_address_bus_in, // core address
	input wire logic [XADDR_W-1:0] expanded_address_bus_in, // paged address
	input wire logic bus_read_in, // 1 read, 0 write cycle
	input wire logic bus_valid_in, // bus cycle qualifier
	input wire logic opcode_exec_in, // tagged opcode about to execute
	input wire logic instr_boundary_in, // next instruction boundary
	output logic break_req_out, // break request to core
	output logic break_to_background_out, // 1 background debug, 0 swi
	output logic break_tagged_out, // request is a tagged break
	output logic breakpoint_only_mode_out, // ab break enable level
	output logic full_mode_out, // effective full mode for a/b
	output logic ab_tagged_out, // effective ab tag select
	output logic c_match_out // raw comparator c match (registered)
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] comparator_c_extended;
	logic [7:0] comparator_c_value_high;
	logic [7:0] comparator_c_value_low;
	logic [7:0] breakpoint_control_two;
	logic capture_unit_enable;
	logic armed;
	logic loop_capture_mode;
	logic c_hit_flag;
	bcc_pkg::bcc_brk_state_t brk_state;

	logic wr_ext, wr_hi, wr_lo, wr_c2, wr_arm;
	logic arm_loop_evt;
	assign wr_ext = reg_wr_in && reg_addr_in == bcc_pkg::OFF_EXT;
	assign wr_hi = reg_wr_in && reg_addr_in == bcc_pkg::OFF_VAL_HIGH;
	assign wr_lo = reg_wr_in && reg_addr_in == bcc_pkg::OFF_VAL_LOW;
	assign wr_c2 = reg_wr_in && reg_addr_in == bcc_pkg::OFF_CTRL_TWO;
	assign wr_arm = reg_wr_in && reg_addr_in == bcc_pkg::OFF_ARM_CTRL;
	// arming with loop capture selected, judged from the written byte
	assign arm_loop_evt = wr_arm && reg_wdata_in[bcc_pkg::ARM_ARM]
		&& reg_wdata_in[bcc_pkg::ARM_LOOP];

	// extended register: plain storage, software owns top compare bits
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			comparator_c_extended <= bcc_pkg::RST_BYTE;
		end else if (wr_ext) begin
			comparator_c_extended <= reg_wdata_in;
		end
	end

	// compare value; loop-mode arm clears it and wins over a same-cycle write
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			comparator_c_value_high <= bcc_pkg::RST_BYTE;
			comparator_c_value_low <= bcc_pkg::RST_BYTE;
		end else if (arm_loop_evt) begin
			comparator_c_value_high <= bcc_pkg::RST_BYTE;
			comparator_c_value_low <= bcc_pkg::RST_BYTE;
		end else begin
			if (wr_hi) begin
				comparator_c_value_high <= reg_wdata_in;
			end
			if (wr_lo) begin
				comparator_c_value_low <= reg_wdata_in;
			end
		end
	end

	// control two; c enable dropped on loop-mode arm
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			breakpoint_control_two <= bcc_pkg::RST_BYTE;
		end else begin
			if (wr_c2) begin
				breakpoint_control_two <= reg_wdata_in;
			end
			if (arm_loop_evt) begin
				breakpoint_control_two[bcc_pkg::C2_C_EN] <= 1'b0;
			end
		end
	end

	// arm/capture control; capture enable refused in breakpoint-only mode
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			capture_unit_enable <= 1'b0;
			armed <= 1'b0;
			loop_capture_mode <= 1'b0;
		end else if (wr_arm) begin
			capture_unit_enable <= reg_wdata_in[bcc_pkg::ARM_CAPTURE_EN]
				&& !breakpoint_control_two[bcc_pkg::C2_AB_EN];
			armed <= reg_wdata_in[bcc_pkg::ARM_ARM];
			loop_capture_mode <= reg_wdata_in[bcc_pkg::ARM_LOOP];
		end
	end

	// ----------------------------------------
	// comparator c match
	// ----------------------------------------
	logic page_on;
	logic [7:0] hi_addr;
	logic hi_ok, lo_ok, ext_ok, dir_ok, c_match;
	// only the low page bit matters; the upper one has no paging behind it
	assign page_on = comparator_c_extended[bcc_pkg::EXT_PAGE_LO];
	// paged: xab 15..14 joined to ab 13..8; unpaged: ab 15..8
	assign hi_addr = page_on ?
		{expanded_address_bus_in[bcc_pkg::XHI_MSB:bcc_pkg::XHI_LSB],
		cpu_address_bus_in[bcc_pkg::AB_HI_MSB:bcc_pkg::AB_HI_LSB]}
		: cpu_address_bus_in[ADDR_W-1:bcc_pkg::AB_HI_LSB];
	assign hi_ok = hi_addr == comparator_c_value_high;
	assign lo_ok = cpu_address_bus_in[bcc_pkg::AB_HI_LSB-1:0] == comparator_c_value_low;
	assign ext_ok = !page_on || (expanded_address_bus_in[bcc_pkg::PAGE_MSB:bcc_pkg::PAGE_LSB]
		== comparator_c_extended[bcc_pkg::EXT_CMP_MSB:0]);
	// direction only counts when qualification is on
	assign dir_ok = !breakpoint_control_two[bcc_pkg::C2_RW_EN]
		|| (bus_read_in == breakpoint_control_two[bcc_pkg::C2_RW_VAL]);
	assign c_match = bus_valid_in && hi_ok && lo_ok && ext_ok && dir_ok;

	// c breaks allowed in breakpoint-only mode, or capture mode outside loop
	logic c_allowed;
	assign c_allowed = breakpoint_control_two[bcc_pkg::C2_C_EN]
		&& (breakpoint_control_two[bcc_pkg::C2_AB_EN]
		|| (capture_unit_enable && !loop_capture_mode));

	// ----------------------------------------
	// a/b mode decode
	// ----------------------------------------
	// full and ab tag are meaningless unless ab break enable is set
	always_comb begin
		breakpoint_only_mode_out = breakpoint_control_two[bcc_pkg::C2_AB_EN];
		full_mode_out = breakpoint_control_two[bcc_pkg::C2_AB_EN]
			&& breakpoint_control_two[bcc_pkg::C2_FULL];
		ab_tagged_out = breakpoint_control_two[bcc_pkg::C2_AB_EN]
			&& breakpoint_control_two[bcc_pkg::C2_TAG_AB];
		break_to_background_out = breakpoint_control_two[bcc_pkg::C2_BDM];
	end

	// ----------------------------------------
	// break request sequencing
	// ----------------------------------------
	// a match waits for the boundary (forced) or the opcode's execution
	// (tagged); a tagged opcode that reaches its boundary unexecuted is
	// dropped, so a later, unrelated execution cannot pick up a stale match
	logic tagged_sel, fire;
	assign tagged_sel = breakpoint_control_two[bcc_pkg::C2_TAG_C];
	assign fire = tagged_sel ? opcode_exec_in : instr_boundary_in;

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			brk_state <= bcc_pkg::BCC_IDLE;
			break_req_out <= 1'b0;
			break_tagged_out <= 1'b0;
			c_match_out <= 1'b0;
		end else begin
			c_match_out <= c_match;
			break_req_out <= 1'b0;
			case (brk_state)
				bcc_pkg::BCC_IDLE: begin
					if (c_match && c_allowed) begin
						brk_state <= bcc_pkg::BCC_PEND;
						break_tagged_out <= tagged_sel;
					end
				end
				bcc_pkg::BCC_PEND: begin
					if (!c_allowed) begin
						brk_state <= bcc_pkg::BCC_IDLE;
					end else if (fire) begin
						break_req_out <= 1'b1;
						brk_state <= bcc_pkg::BCC_SENT;
					end else if (tagged_sel && instr_boundary_in) begin
						// boundary passed and the opcode did not execute
						brk_state <= bcc_pkg::BCC_IDLE;
					end
				end
				bcc_pkg::BCC_SENT: begin
					brk_state <= bcc_pkg::BCC_IDLE;
				end
				default: begin
					brk_state <= bcc_pkg::BCC_IDLE;
				end
			endcase
		end
	end

	// sticky hit flag; set wins over the clear-on-write
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			c_hit_flag <= 1'b0;
		end else if (c_match && c_allowed) begin
			c_hit_flag <= 1'b1;
		end else if (reg_wr_in && reg_addr_in == bcc_pkg::OFF_STATUS) begin
			c_hit_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// read back; unmapped offsets read zero
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			reg_rdata_out <= bcc_pkg::RST_BYTE;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				bcc_pkg::OFF_EXT: reg_rdata_out <= comparator_c_extended;
				bcc_pkg::OFF_VAL_HIGH: reg_rdata_out <= comparator_c_value_high;
				bcc_pkg::OFF_VAL_LOW: reg_rdata_out <= comparator_c_value_low;
				bcc_pkg::OFF_CTRL_TWO: reg_rdata_out <= breakpoint_control_two;
				bcc_pkg::OFF_ARM_CTRL: reg_rdata_out <= {capture_unit_enable, armed,
					5'h00, loop_capture_mode};
				bcc_pkg::OFF_STATUS: reg_rdata_out <= {7'h00, c_hit_flag};
				default: reg_rdata_out <= bcc_pkg::RST_BYTE;
			endcase
		end else begin
			reg_rdata_out <= bcc_pkg::RST_BYTE;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// register writes land unless a loop-mode arm takes precedence
	ext_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		wr_ext |=> comparator_c_extended == $past(reg_wdata_in))
		else $error("extended register write lost");
	value_high_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr_hi && !arm_loop_evt) |=> comparator_c_value_high == $past(reg_wdata_in))
		else $error("compare value high write lost");
	value_low_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr_lo && !arm_loop_evt) |=> comparator_c_value_low == $past(reg_wdata_in))
		else $error("compare value low write lost");
	ctrl_write_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr_c2 && !arm_loop_evt) |=> breakpoint_control_two == $past(reg_wdata_in))
		else $error("control two write lost");
	loop_arm_clear_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		arm_loop_evt |=> comparator_c_value_high == bcc_pkg::RST_BYTE
		&& comparator_c_value_low == bcc_pkg::RST_BYTE)
		else $error("compare value not cleared on loop arm");
	loop_arm_cen_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		arm_loop_evt |=> !breakpoint_control_two[bcc_pkg::C2_C_EN])
		else $error("c enable survived loop arm");

	// capture enable follows the write only outside breakpoint-only mode
	capture_refused_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr_arm && breakpoint_control_two[bcc_pkg::C2_AB_EN]) |=> !capture_unit_enable)
		else $error("capture enabled in breakpoint-only mode");
	capture_taken_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr_arm && !breakpoint_control_two[bcc_pkg::C2_AB_EN]
		&& reg_wdata_in[bcc_pkg::ARM_CAPTURE_EN]) |=> capture_unit_enable)
		else $error("capture enable write lost");
	loop_taken_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(wr_arm && reg_wdata_in[bcc_pkg::ARM_LOOP]) |=> loop_capture_mode)
		else $error("loop capture select write lost");

	// a/b qualifiers pass through only with ab break enable set; break destination follows control two regardless
	ab_bits_masked_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!breakpoint_control_two[bcc_pkg::C2_AB_EN] |-> !full_mode_out && !ab_tagged_out)
		else $error("full or ab tag active with ab break off");
	full_mode_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		breakpoint_control_two[bcc_pkg::C2_AB_EN]
		|-> full_mode_out == breakpoint_control_two[bcc_pkg::C2_FULL])
		else $error("full mode select not passed on");
	ab_tag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		breakpoint_control_two[bcc_pkg::C2_AB_EN]
		|-> ab_tagged_out == breakpoint_control_two[bcc_pkg::C2_TAG_AB])
		else $error("ab tag select not passed on");
	break_dest_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		break_req_out |-> break_to_background_out == breakpoint_control_two[bcc_pkg::C2_BDM])
		else $error("break destination differs from control two");

	// every enabled part of the comparator c match must hold
	valid_needed_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		!bus_valid_in |-> !c_match)
		else $error("match without a valid bus cycle");
	low_byte_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		c_match |-> cpu_address_bus_in[bcc_pkg::AB_HI_LSB-1:0] == comparator_c_value_low)
		else $error("match with wrong low address byte");
	unpaged_ignore_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!page_on && bus_valid_in && dir_ok
		&& cpu_address_bus_in == {comparator_c_value_high, comparator_c_value_low})
		|-> c_match)
		else $error("unpaged compare missed address");
	unpaged_high_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(c_match && !page_on)
		|-> cpu_address_bus_in[ADDR_W-1:bcc_pkg::AB_HI_LSB] == comparator_c_value_high)
		else $error("unpaged match with wrong high byte");
	paged_match_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(c_match && page_on) |-> expanded_address_bus_in[bcc_pkg::PAGE_MSB:bcc_pkg::PAGE_LSB]
		== comparator_c_extended[bcc_pkg::EXT_CMP_MSB:0])
		else $error("paged match with wrong page");
	paged_high_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(c_match && page_on)
		|-> {expanded_address_bus_in[bcc_pkg::XHI_MSB:bcc_pkg::XHI_LSB],
		cpu_address_bus_in[bcc_pkg::AB_HI_MSB:bcc_pkg::AB_HI_LSB]} == comparator_c_value_high)
		else $error("paged match with wrong high byte");
	dir_qualify_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(c_match && breakpoint_control_two[bcc_pkg::C2_RW_EN])
		|-> bus_read_in == breakpoint_control_two[bcc_pkg::C2_RW_VAL])
		else $error("direction mismatch gave a match");
	dir_ignored_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(bus_valid_in && hi_ok && lo_ok && ext_ok
		&& !breakpoint_control_two[bcc_pkg::C2_RW_EN]) |-> c_match)
		else $error("direction counted with qualify off");
	match_registered_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		c_match |=> c_match_out)
		else $error("match output lagged");

	// break request: a single pulse, only out of a pending match
	forced_fire_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(brk_state == bcc_pkg::BCC_PEND && c_allowed && !tagged_sel && instr_boundary_in)
		|=> break_req_out ##1 !break_req_out)
		else $error("forced break not one pulse at boundary");
	tagged_fire_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(brk_state == bcc_pkg::BCC_PEND && c_allowed && tagged_sel && opcode_exec_in)
		|=> break_req_out)
		else $error("tagged break missed the executed opcode");
	tagged_drop_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(brk_state == bcc_pkg::BCC_PEND && c_allowed && tagged_sel && instr_boundary_in
		&& !opcode_exec_in) |=> !break_req_out && brk_state == bcc_pkg::BCC_IDLE)
		else $error("unexecuted tagged opcode kept its break");
	tag_latched_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(brk_state == bcc_pkg::BCC_IDLE && c_match && c_allowed)
		|=> break_tagged_out == $past(tagged_sel))
		else $error("break kind not latched at match");
	req_from_pend_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		break_req_out |-> brk_state == bcc_pkg::BCC_SENT)
		else $error("break request outside the sent state");
	sent_returns_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		brk_state == bcc_pkg::BCC_SENT |=> brk_state == bcc_pkg::BCC_IDLE && !break_req_out)
		else $error("break request held past one cycle");
	pend_dropped_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(brk_state == bcc_pkg::BCC_PEND && !c_allowed)
		|=> brk_state == bcc_pkg::BCC_IDLE && !break_req_out)
		else $error("pending break kept after c breaks went off");
	loop_blocks_c_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!breakpoint_control_two[bcc_pkg::C2_AB_EN] && loop_capture_mode
		&& brk_state == bcc_pkg::BCC_IDLE) |=> brk_state == bcc_pkg::BCC_IDLE)
		else $error("c break armed in loop capture");
	cen_off_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!breakpoint_control_two[bcc_pkg::C2_C_EN] && brk_state == bcc_pkg::BCC_IDLE)
		|=> brk_state == bcc_pkg::BCC_IDLE)
		else $error("c break armed with c enable off");
	hit_flag_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(c_match && c_allowed) |=> c_hit_flag)
		else $error("hit flag missed a c match");
endmodule

//--- hw/bcc_pkg.sv
package bcc_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_EXT = 8'h25;
	localparam logic [7:0] OFF_VAL_HIGH = 8'h26;
	localparam logic [7:0] OFF_VAL_LOW = 8'h27;
	localparam logic [7:0] OFF_CTRL_TWO = 8'h28;
	// mode/arm control register (capture enable, arm, loop select)
	localparam logic [7:0] OFF_ARM_CTRL = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h21;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int EXT_PAGE_LO = 6;
	localparam int EXT_CMP_MSB = 5;
	localparam int C2_AB_EN = 7;
	localparam int C2_FULL = 6;
	localparam int C2_BDM = 5;
	localparam int C2_TAG_AB = 4;
	localparam int C2_C_EN = 3;
	localparam int C2_TAG_C = 2;
	localparam int C2_RW_EN = 1;
	localparam int C2_RW_VAL = 0;
	localparam int ARM_CAPTURE_EN = 7;
	localparam int ARM_ARM = 6;
	localparam int ARM_LOOP = 0;

	// ----------------------------------------
	// reset values and widths
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int ADDR_W = 16;
	localparam int XADDR_W = 22;
	localparam int PAGE_MSB = 21;
	localparam int PAGE_LSB = 16;
	localparam int XHI_MSB = 15;
	localparam int XHI_LSB = 14;
	localparam int AB_HI_MSB = 13;
	localparam int AB_HI_LSB = 8;

	typedef enum logic [1:0] {
		BCC_IDLE = 2'b00,
		BCC_PEND = 2'b01,
		BCC_SENT = 2'b10
	} bcc_brk_state_t;
endpackage
